// File: logic/tws_map.vh
/*
  Constants of the two-wire status and arbitration unit: status codes,
  own-address fields, timing figures and master state codes.
  Assumes a 50 MHz system clock and an open-drain SDA/SCL bus outside.
*/
// How it works
// - STOP or repeated START while addressed as slave reports 0xA0, sets flag.
// - clearing after 0xA0 with acknowledge low leaves an unaddressed, deaf slave.
// - clearing after 0xA0 with acknowledge high re-arms own and general-call match.
// - clearing after 0xA0 with start request sends START once bus is free.
// - status reads 0xF8 whenever the job-done flag is clear.
// - START or STOP inside a byte or acknowledge bit reports bus error 0x00.
// - a bus error sets the job-done flag.
// - stop request plus flag clear recovers: unaddressed; stop request cleared unless the master was running.
// - recovery releases SDA and SCL and sends no STOP on the bus.
// - master turns direction with a repeated START and keeps the bus.
// - simultaneous masters with differing traffic: one proceeds, shifted data is kept.
// - identical traffic from several masters raises no arbitration loss.
// - a master sending one while SDA reads zero loses arbitration.
// - loss in data bits: unaddressed slave or new START.
// - loss in address bits: check own address, become addressed slave if hit.
// - own address in upper seven bits, bit zero enables general call 0x00.
// - writing one to the job-done flag clears it and starts the next step.
// - while the job-done flag is set and addressed or master running, SCL low is stretched.
`ifndef TWS_MAP_VH
`define TWS_MAP_VH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TWS_CLK_NS       20
`define TWS_SCL_HALF_NS  5000
`define TWS_SCL_HALF_CYC ((`TWS_SCL_HALF_NS + `TWS_CLK_NS - 1) / `TWS_CLK_NS)

// ----------------------------------------------------------------------
// own address fields
// ----------------------------------------------------------------------
`define TWS_OWN_GCE      0
`define TWS_GENERAL_CALL 8'h00

// ----------------------------------------------------------------------
// status codes
// ----------------------------------------------------------------------
`define TWS_ST_IDLE   8'hF8
`define TWS_ST_BUSERR 8'h00
`define TWS_ST_START  8'h08
`define TWS_ST_RSTART 8'h10
`define TWS_ST_MTA_AK 8'h18
`define TWS_ST_MTA_NK 8'h20
`define TWS_ST_MTD_AK 8'h28
`define TWS_ST_MTD_NK 8'h30
`define TWS_ST_ARBL   8'h38
`define TWS_ST_MRA_AK 8'h40
`define TWS_ST_MRA_NK 8'h48
`define TWS_ST_MRD_AK 8'h50
`define TWS_ST_MRD_NK 8'h58
`define TWS_ST_SRA    8'h60
`define TWS_ST_SRA_AL 8'h68
`define TWS_ST_SRG    8'h70
`define TWS_ST_SRG_AL 8'h78
`define TWS_ST_SRD_AK 8'h80
`define TWS_ST_SRD_NK 8'h88
`define TWS_ST_SGD_AK 8'h90
`define TWS_ST_SGD_NK 8'h98
`define TWS_ST_STOPRS 8'hA0
`define TWS_ST_STA    8'hA8
`define TWS_ST_STA_AL 8'hB0
`define TWS_ST_STD_AK 8'hB8
`define TWS_ST_STD_NK 8'hC0

// ----------------------------------------------------------------------
// master sequencer states, one-hot
// ----------------------------------------------------------------------
`define TWS_M_IDLE   5'h01
`define TWS_M_START  5'h02
`define TWS_M_RUN    5'h04
`define TWS_M_STOP   5'h08
`define TWS_M_RSTART 5'h10

`endif

// File: logic/tws_sync.v
/*
  Two-stage synchroniser for a group of asynchronous level inputs.
  Assumes the inputs are levels; only the second stage may be read.
*/
`timescale 1ns/1ns
module tws_sync #(
  parameter W = 2
) (
  input  wire         clk,
  input  wire         arst_n,
  input  wire         ce,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;

  // two flops, idle bus level after reset
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= {W{1'b1}};
      q    <= {W{1'b1}};
    end else if (ce) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // tws_sync

// File: logic/tws_unit.v
/*
  Two-wire serial unit: shared bit engine for slave and master roles,
  status reporting, bus-error recovery, repeated START and arbitration.
  Assumes open-drain SDA/SCL resolved outside; software ports are on CLK.
*/
`timescale 1ns/1ns
`include "tws_map.vh"
module tws_unit #(
  parameter [15:0] SCL_HALF = `TWS_SCL_HALF_CYC
) (
  // clock, reset, enable
  input  wire       CLK,
  input  wire       ARST_N,
  input  wire       CE,
  // two-wire bus pins
  input  wire       SCL_I,
  output reg        SCL_O,
  output reg        SCL_OE_N,
  input  wire       SDA_I,
  output reg        SDA_O,
  output reg        SDA_OE_N,
  // interface control register write
  input  wire       CTRL_WR,
  input  wire       CTRL_INT_CLR,
  input  wire       CTRL_EA,
  input  wire       CTRL_STA,
  input  wire       CTRL_STO,
  input  wire       CTRL_EN,
  // shift data register and own address register
  input  wire       DATA_WR,
  input  wire [7:0] DATA_IN,
  input  wire [7:0] OWN_ADDR,
  // status outputs
  output reg  [7:0] DATA_OUT,
  output reg  [7:0] STATUS,
  output reg        JOB_DONE,
  output reg        STOP_REQ,
  output reg        ADDRESSED
);
  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  wire [1:0] pin_s;
  reg        scl_p, sda_p;
  reg        ea, start_request_bit, en;
  reg  [3:0] bit_cnt;
  reg        in_frame, addr_phase, bus_busy;
  reg        rd, general_call_address, lost, rep, ph;
  reg        m_scl_low, m_sda_low;
  reg  [4:0] mstate;
  reg  [15:0] tmr;
  reg        ev;
  reg  [7:0] code;

  // recovery-type codes drop the addressed state on clear
  function unaddr_code;
    input [7:0] c;
    begin
      unaddr_code = (c == `TWS_ST_STOPRS) || (c == `TWS_ST_BUSERR) ||
                    (c == `TWS_ST_ARBL)   || (c == `TWS_ST_SRD_NK) ||
                    (c == `TWS_ST_SGD_NK) || (c == `TWS_ST_STD_NK);
    end
  endfunction

  // ----------------------------------------------------------------------
  // pin sampling and bus condition detection
  // ----------------------------------------------------------------------
  tws_sync #(.W(2)) u_sync (
    .clk    (CLK),
    .arst_n (ARST_N),
    .ce     (CE),
    .d      ({SCL_I, SDA_I}),
    .q      (pin_s)
  );

  wire scl_s     = pin_s[1];
  wire sda_s     = pin_s[0];
  wire scl_rise  = scl_s & ~scl_p;
  wire scl_fall  = ~scl_s & scl_p;
  wire start_c   = sda_p & ~sda_s & scl_s & scl_p;
  wire stop_c    = ~sda_p & sda_s & scl_s & scl_p;
  wire mid_frame = in_frame & (bit_cnt != 4'h0);
  wire mst_run   = (mstate == `TWS_M_RUN);
  wire clr_req   = CTRL_WR & CTRL_INT_CLR & JOB_DONE;

  // roles for the current byte
  wire tx_role = (mst_run & (addr_phase | ~rd)) |
                 (~mst_run & ADDRESSED & rd & ~addr_phase);
  wire rx_role = (mst_run & rd) | (~mst_run & ADDRESSED & ~rd);
  wire want_low = (bit_cnt == 4'h8) ?
                  (addr_phase ? (ADDRESSED & ~mst_run) : (rx_role & ea)) :
                  (tx_role & ~DATA_OUT[7]);

  // released SDA reading zero while sending a one loses the bus
  wire lose_now = scl_rise & in_frame & mst_run & tx_role &
                  (bit_cnt != 4'h8) & SDA_OE_N & ~sda_s;
  wire [7:0] rx_byte = {DATA_OUT[6:0], sda_s};
  wire hit_own = ea & (rx_byte[7:1] == OWN_ADDR[7:1]);
  wire hit_gc  = ea & OWN_ADDR[`TWS_OWN_GCE] &
                 (rx_byte == `TWS_GENERAL_CALL);
  wire ackd    = ~sda_s;
  wire stretch = JOB_DONE & (ADDRESSED | mst_run) & ~scl_s;

  // ----------------------------------------------------------------------
  // event decode: which status the unit raises this cycle
  // ----------------------------------------------------------------------
  always @* begin
    ev   = 1'b0;
    code = `TWS_ST_IDLE;
    if (mstate == `TWS_M_START && tmr == SCL_HALF) begin
      ev   = 1'b1;
      code = rep ? `TWS_ST_RSTART : `TWS_ST_START;
    end
    if (scl_rise && in_frame && bit_cnt == 4'h8) begin
      if (mst_run) begin
        ev = 1'b1;
        if (addr_phase)
          code = DATA_OUT[0] ?
                 (ackd ? `TWS_ST_MRA_AK : `TWS_ST_MRA_NK) :
                 (ackd ? `TWS_ST_MTA_AK : `TWS_ST_MTA_NK);
        else
          code = rd ? (ackd ? `TWS_ST_MRD_AK : `TWS_ST_MRD_NK) :
                      (ackd ? `TWS_ST_MTD_AK : `TWS_ST_MTD_NK);
      end else if (ADDRESSED) begin
        ev = 1'b1;
        if (addr_phase)
          code = rd ? (lost ? `TWS_ST_STA_AL : `TWS_ST_STA) :
                 general_call_address ? (lost ? `TWS_ST_SRG_AL : `TWS_ST_SRG) :
                       (lost ? `TWS_ST_SRA_AL : `TWS_ST_SRA);
        else if (rd)
          code = ackd ? `TWS_ST_STD_AK : `TWS_ST_STD_NK;
        else
          code = general_call_address ? (ackd ? `TWS_ST_SGD_AK : `TWS_ST_SGD_NK) :
                       (ackd ? `TWS_ST_SRD_AK : `TWS_ST_SRD_NK);
      end else if (lost) begin
        ev   = 1'b1;
        code = `TWS_ST_ARBL;
      end
    end
    if ((start_c || stop_c) && ADDRESSED && !mst_run) begin
      ev   = 1'b1;
      code = `TWS_ST_STOPRS;
    end
    if ((start_c || stop_c) && mid_frame) begin
      ev   = 1'b1;
      code = `TWS_ST_BUSERR;
    end
  end

  // ----------------------------------------------------------------------
  // control, bit engine, master sequencer and pin drivers
  // ----------------------------------------------------------------------
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      scl_p <= 1'b1;   sda_p <= 1'b1;
      ea <= 1'b0;      start_request_bit <= 1'b0;      en <= 1'b0;
      bit_cnt <= 4'h0; in_frame <= 1'b0; addr_phase <= 1'b0;
      bus_busy <= 1'b0; rd <= 1'b0;      general_call_address <= 1'b0;
      lost <= 1'b0;    rep <= 1'b0;      ph <= 1'b0;
      m_scl_low <= 1'b0; m_sda_low <= 1'b0;
      mstate <= `TWS_M_IDLE; tmr <= 16'h0000;
      SCL_O <= 1'b0;   SCL_OE_N <= 1'b1;
      SDA_O <= 1'b0;   SDA_OE_N <= 1'b1;
      DATA_OUT <= 8'hFF; STATUS <= `TWS_ST_IDLE;
      JOB_DONE <= 1'b0; STOP_REQ <= 1'b0; ADDRESSED <= 1'b0;
    end else if (CE) begin
      scl_p <= scl_s;
      sda_p <= sda_s;
      // software writes; clear comes first so a new event wins
      if (CTRL_WR) begin
        ea       <= CTRL_EA;
        start_request_bit      <= CTRL_STA;
        STOP_REQ <= CTRL_STO;
        en       <= CTRL_EN;
      end
      if (clr_req) begin
        JOB_DONE <= 1'b0;
        STATUS   <= `TWS_ST_IDLE;
        lost     <= 1'b0;
        if (unaddr_code(STATUS))
          ADDRESSED <= 1'b0;
        if (CTRL_STO && !mst_run) begin
          ADDRESSED <= 1'b0;
          STOP_REQ  <= 1'b0;
          in_frame  <= 1'b0;
        end
      end
      if (DATA_WR && JOB_DONE)
        DATA_OUT <= DATA_IN;
      // bus conditions
      // the SCL fall that ends the START wraps the count to bit 0
      if (start_c) begin
        in_frame   <= 1'b1;
        addr_phase <= 1'b1;
        bit_cnt    <= 4'hF;
        bus_busy   <= 1'b1;
      end
      if (stop_c) begin
        in_frame <= 1'b0;
        bus_busy <= 1'b0;
      end
      // bit sampling and address match
      if (scl_rise && in_frame) begin
        if (bit_cnt != 4'h8)
          DATA_OUT <= rx_byte;                 // data bits always kept
        if (lose_now) begin
          lost   <= 1'b1;
          mstate <= `TWS_M_IDLE;
        end
        if (bit_cnt == 4'h7 && addr_phase && (!mst_run || lose_now) &&
            (hit_own || hit_gc)) begin
          ADDRESSED <= 1'b1;
          rd        <= rx_byte[0];
          general_call_address       <= hit_gc;
        end
        if (bit_cnt == 4'h8) begin
          addr_phase <= 1'b0;
          if (addr_phase && mst_run)
            rd <= DATA_OUT[0];                 // direction of own address
        end
      end
      if (scl_fall && in_frame)
        bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      // raise status and job-done flag
      if (ev) begin
        JOB_DONE <= 1'b1;
        STATUS   <= code;
        if (code == `TWS_ST_BUSERR) begin
          in_frame   <= 1'b0;
          addr_phase <= 1'b0;
        end
      end
      // master sequencer
      case (mstate)
        `TWS_M_IDLE: begin
          m_scl_low <= 1'b0;
          m_sda_low <= 1'b0;
          tmr       <= 16'h0000;
          if (en && start_request_bit && !bus_busy && !JOB_DONE) begin
            mstate    <= `TWS_M_START;
            m_sda_low <= 1'b1;
            rep       <= 1'b0;
          end
        end
        `TWS_M_START: begin
          tmr <= tmr + 16'h0001;
          if (tmr == SCL_HALF) begin
            m_scl_low <= 1'b1;
            tmr       <= 16'h0000;
            mstate    <= `TWS_M_RUN;
          end
        end
        `TWS_M_RUN: begin
          if (m_scl_low) begin
            if (!JOB_DONE)
              tmr <= tmr + 16'h0001;
            if (tmr == SCL_HALF) begin
              m_scl_low <= 1'b0;
              tmr       <= 16'h0000;
            end
          end else if (scl_s) begin
            tmr <= tmr + 16'h0001;
            if (tmr == SCL_HALF) begin
              m_scl_low <= 1'b1;
              tmr       <= 16'h0000;
            end
          end
          if (clr_req) begin
            tmr <= 16'h0000;
            ph  <= 1'b0;
            if (CTRL_STO && STATUS == `TWS_ST_BUSERR)
              mstate <= `TWS_M_IDLE;
            else if (CTRL_STO)
              mstate <= `TWS_M_STOP;
            else if (CTRL_STA)
              mstate <= `TWS_M_RSTART;
          end
          if (lose_now)
            mstate <= `TWS_M_IDLE;
        end
        `TWS_M_STOP: begin
          m_sda_low <= 1'b1;
          if (!ph) begin
            tmr <= tmr + 16'h0001;
            if (tmr == SCL_HALF) begin
              m_scl_low <= 1'b0;
              ph        <= 1'b1;
              tmr       <= 16'h0000;
            end
          end else if (scl_s) begin
            tmr <= tmr + 16'h0001;
            if (tmr == SCL_HALF) begin
              m_sda_low <= 1'b0;
              STOP_REQ  <= 1'b0;
              mstate    <= `TWS_M_IDLE;
            end
          end
        end
        `TWS_M_RSTART: begin
          if (!ph) begin
            m_sda_low <= 1'b0;
            tmr       <= tmr + 16'h0001;
            if (tmr == SCL_HALF) begin
              m_scl_low <= 1'b0;
              ph        <= 1'b1;
              tmr       <= 16'h0000;
            end
          end else if (scl_s) begin
            tmr <= tmr + 16'h0001;
            if (tmr == SCL_HALF) begin
              m_sda_low <= 1'b1;       // bus kept, no STOP between
              rep       <= 1'b1;
              tmr       <= 16'h0000;
              mstate    <= `TWS_M_START;
            end
          end
        end
        default: begin
          mstate <= `TWS_M_IDLE;
        end
      endcase
      // pin drivers; identical bits from rivals never trip a loss
      SCL_OE_N <= ~(stretch | m_scl_low);
      if (!(mstate == `TWS_M_IDLE || mst_run))
        SDA_OE_N <= ~m_sda_low;
      else if (!in_frame)
        SDA_OE_N <= 1'b1;
      else if (!scl_s)
        SDA_OE_N <= ~want_low;
    end
  end
endmodule // tws_unit

// File: test/two_wire_status_and_arbitration_tb_top.sv
/*
  Bench for the two-wire unit: slave traffic, stop codes, start request,
  bus error and recovery. Assumes the unit, its map and the peer model.
*/
`timescale 1ns/1ns
module two_wire_status_and_arbitration_tb_top;
  reg        clk, arst_n, ctrl_wr, ctrl_int_clr, ctrl_ea, ctrl_sta, ctrl_sto;
  reg  [7:0] own_addr;
  wire       scl_o, scl_oe_n, sda_o, sda_oe_n, peer_scl, peer_sda;
  wire       job_done, stop_req, addressed;
  wire [7:0] data_out, status;
  logic      ack;
  integer    n_errors, compares;
  // wired-and bus with pull-ups
  wire scl = peer_scl & (scl_oe_n | scl_o);
  wire sda = peer_sda & (sda_oe_n | sda_o);

  tws_unit #(.SCL_HALF(16'h0004)) dut (
    .CLK(clk), .ARST_N(arst_n), .CE(1'b1), .SCL_I(scl), .SCL_O(scl_o),
    .SCL_OE_N(scl_oe_n), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n),
    .CTRL_WR(ctrl_wr), .CTRL_INT_CLR(ctrl_int_clr), .CTRL_EA(ctrl_ea),
    .CTRL_STA(ctrl_sta), .CTRL_STO(ctrl_sto), .CTRL_EN(1'b1),
    .DATA_WR(1'b0), .DATA_IN(8'h00), .OWN_ADDR(own_addr),
    .DATA_OUT(data_out), .STATUS(status), .JOB_DONE(job_done),
    .STOP_REQ(stop_req), .ADDRESSED(addressed));
  tws_peer peer (.scl(scl), .sda(sda), .scl_od(peer_scl), .sda_od(peer_sda));

  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // compare and count
  task check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        $display("ERROR %s expected %h seen %h", nm, exp, got);
        n_errors = n_errors + 1;
      end
    end
  endtask

  // one-cycle control write at falling edges
  task ctrl(input logic clr, input logic ea, input logic start_request_bit, input logic stop_request_bit);
    begin
      @(negedge clk);
      ctrl_wr = 1'b1;
      ctrl_int_clr = clr;
      ctrl_ea = ea;
      ctrl_sta = start_request_bit;
      ctrl_sto = stop_request_bit;
      @(negedge clk);
      ctrl_wr = 1'b0;
      ctrl_int_clr = 1'b0;
    end
  endtask

  // bounded wait for the job-done flag
  task wait_done;
    integer i;
    begin
      for (i = 0; i < 3000 && job_done !== 1'b1; i = i + 1) begin
        @(negedge clk);
      end
      check("job_done", {7'h00, job_done}, 8'h01);
    end
  endtask

  // verdict and end of run
  task stop_test;
    begin
      if (n_errors == 0 && compares > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // watchdog
  initial begin
    #500000;
    n_errors = n_errors + 1;
    stop_test;
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    n_errors = 0;
    compares = 0;
    arst_n = 1'b0;
    {ctrl_wr, ctrl_int_clr, ctrl_ea, ctrl_sta, ctrl_sto} = 5'h00;
    own_addr = 8'h55; // own address 0x2A, general call enabled
    repeat (20) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    check("status", status, 8'hF8);
    ctrl(1'b0, 1'b1, 1'b0, 1'b0);
    // addressed write, data byte, stop
    peer.start_cond;
    peer.send_byte(8'h54, ack);
    check("ack", {7'h00, ack}, 8'h00);
    wait_done;
    check("status", status, 8'h60);
    ctrl(1'b1, 1'b1, 1'b0, 1'b0);
    check("status", status, 8'hF8);
    peer.send_byte(8'hA5, ack);
    wait_done;
    check("status", status, 8'h80);
    check("data_out", data_out, 8'hA5);
    ctrl(1'b1, 1'b1, 1'b0, 1'b0);
    peer.stop_cond;
    wait_done;
    check("status", status, 8'hA0);
    // clear with acknowledge low: deaf slave
    ctrl(1'b1, 1'b0, 1'b0, 1'b0);
    check("addressed", {7'h00, addressed}, 8'h00);
    peer.start_cond;
    peer.send_byte(8'h54, ack);
    check("ack", {7'h00, ack}, 8'h01);
    check("job_done", {7'h00, job_done}, 8'h00);
    peer.stop_cond;
    // general call, then repeated start while addressed
    ctrl(1'b0, 1'b1, 1'b0, 1'b0);
    peer.start_cond;
    peer.send_byte(8'h00, ack);
    check("ack", {7'h00, ack}, 8'h00);
    wait_done;
    check("status", status, 8'h70);
    ctrl(1'b1, 1'b1, 1'b0, 1'b0);
    peer.start_cond; // repeated start, bus kept between steps
    wait_done;
    check("status", status, 8'hA0);
    // clear with acknowledge high: own address heard again
    ctrl(1'b1, 1'b1, 1'b0, 1'b0);
    peer.send_byte(8'h54, ack);
    check("ack", {7'h00, ack}, 8'h00);
    wait_done;
    check("status", status, 8'h60);
    ctrl(1'b1, 1'b1, 1'b0, 1'b0);
    peer.stop_cond;
    wait_done;
    check("status", status, 8'hA0);
    // clear with start request: start once bus is free
    ctrl(1'b1, 1'b1, 1'b1, 1'b0);
    wait_done;
    check("status", status, 8'h08);
    check("sda_oe_n", {7'h00, sda_oe_n}, 8'h00);
    ctrl(1'b1, 1'b1, 1'b0, 1'b1);
    repeat (60) @(negedge clk);
    check("stop_req", {7'h00, stop_req}, 8'h00);
    check("scl_oe_n", {7'h00, scl_oe_n}, 8'h01);
    // stop inside an address byte: bus error and recovery
    peer.start_cond;
    repeat (4) peer.put_bit(1'b1, ack);
    peer.stop_cond;
    wait_done;
    check("status", status, 8'h00);
    ctrl(1'b1, 1'b1, 1'b0, 1'b1);
    check("job_done", {7'h00, job_done}, 8'h00);
    check("status", status, 8'hF8);
    check("stop_req", {7'h00, stop_req}, 8'h00);
    check("addressed", {7'h00, addressed}, 8'h00);
    check("lines", {6'h00, sda_oe_n, scl_oe_n}, 8'h03);
    stop_test;
  end
endmodule // two_wire_status_and_arbitration_tb_top

// File: test/tws_peer.sv
/*
  Other master on the shared bus, behavioural, 160 ns bit period.
  Assumes pulled-up wires resolved by the bench; 1 on a drive = released.
*/
`timescale 1ns/1ns
module tws_peer (
  // resolved wires
  input wire scl,
  input wire sda,
  // open-drain drives
  output reg scl_od,
  output reg sda_od
);
  localparam HALF = 80;

  // bus idle, clock still outside frames
  initial begin
    scl_od = 1'b1;
    sda_od = 1'b1;
  end

  // start or repeated start: sda falls with scl high
  task start_cond;
    begin
      #(HALF/2) sda_od = 1'b1;
      #(HALF/2) scl_od = 1'b1;
      wait (scl === 1'b1); // honour stretching
      #HALF sda_od = 1'b0;
      #HALF scl_od = 1'b0;
    end
  endtask

  // stop: sda rises with scl high
  task stop_cond;
    begin
      #(HALF/2) sda_od = 1'b0;
      #(HALF/2) scl_od = 1'b1;
      wait (scl === 1'b1);
      #HALF sda_od = 1'b1;
      #HALF;
    end
  endtask

  // one bit; data changes only while scl low
  task put_bit(input logic b, output logic s);
    begin
      #(HALF/2) sda_od = b;
      #(HALF/2) scl_od = 1'b1;
      wait (scl === 1'b1);
      #(HALF/2) s = sda;
      #(HALF/2) scl_od = 1'b0;
    end
  endtask

  // byte msb first, then released acknowledge bit
  task send_byte(input logic [7:0] b, output logic ack);
    integer i;
    logic   s;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        put_bit(b[i], s);
      end
      put_bit(1'b1, ack);
    end
  endtask
endmodule // tws_peer

// File: test/tws_unit_monitor.sv
/*
  Checker for the two-wire unit: status, flag, stretch and recovery.
  Assumes it is bound to the unit; sees only the unit's ports.
*/
`timescale 1ns/1ns
module tws_unit_monitor #(
  parameter [15:0] SCL_HALF = 16'h0004
) (
  // clock and reset
  input wire       CLK,
  input wire       ARST_N,
  // control writes
  input wire       CTRL_WR,
  input wire       CTRL_INT_CLR,
  input wire       CTRL_STO,
  // bus enables
  input wire       SCL_OE_N,
  input wire       SDA_OE_N,
  // status
  input wire [7:0] STATUS,
  input wire       JOB_DONE,
  input wire       STOP_REQ,
  input wire       ADDRESSED
);
  default clocking tws_cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_idle_status: assert property (
    !JOB_DONE |-> STATUS == 8'hF8) else $error("status not idle");
  chk_a0_cause: assert property (
    $rose(JOB_DONE) && STATUS == 8'hA0 |-> $past(ADDRESSED))
    else $error("stop code without addressing");
  chk_a0_unaddr: assert property (
    JOB_DONE && STATUS == 8'hA0 && CTRL_WR && CTRL_INT_CLR
    |=> !ADDRESSED && !JOB_DONE) else $error("still addressed");
  chk_stretch_hold: assert property (
    JOB_DONE && !SCL_OE_N && !(CTRL_WR && CTRL_INT_CLR) |=> !SCL_OE_N)
    else $error("scl released while flag set");
  chk_flag_stands: assert property (
    JOB_DONE && !(CTRL_WR && CTRL_INT_CLR) |=> JOB_DONE && $stable(STATUS))
    else $error("flag or code moved without clear");
  chk_error_release: assert property (
    $rose(JOB_DONE) && STATUS == 8'h00 |-> ##[0:3] SDA_OE_N && SCL_OE_N)
    else $error("lines held after bus error");
  chk_recover_state: assert property (
    JOB_DONE && STATUS == 8'h00 && CTRL_WR && CTRL_INT_CLR && CTRL_STO
    |=> !STOP_REQ && !ADDRESSED && !JOB_DONE) else $error("bad recovery");
  chk_recover_lines: assert property (
    JOB_DONE && STATUS == 8'h00 && CTRL_WR && CTRL_INT_CLR && CTRL_STO
    |=> (SDA_OE_N && SCL_OE_N)[*4]) else $error("bus driven in recovery");
endmodule // tws_unit_monitor

bind tws_unit tws_unit_monitor #(.SCL_HALF(SCL_HALF)) u_mon (
  .CLK(CLK), .ARST_N(ARST_N), .CTRL_WR(CTRL_WR),
  .CTRL_INT_CLR(CTRL_INT_CLR), .CTRL_STO(CTRL_STO),
  .SCL_OE_N(SCL_OE_N), .SDA_OE_N(SDA_OE_N), .STATUS(STATUS),
  .JOB_DONE(JOB_DONE), .STOP_REQ(STOP_REQ), .ADDRESSED(ADDRESSED));
